// [src/tw_rx_params.svh]
`ifndef TW_RX_PARAMS_SVH
`define TW_RX_PARAMS_SVH
`define TWC_CTRL_OFS 'h0
`define TWC_STAT_OFS 'h4
`define TWC_DATA_OFS 'h8
`define TWC_MODE_OFS 'hC
`define TWC_FLAG 7
`define TWC_ACK 6
`define TWC_STA 5
`define TWC_STO 4
`define TWC_WCOL 3
`define TWC_EN 2
`define TWC_IE 0
`define TWC_DATA_RST 8'hFF
`define TWC_STAT_RST 8'hF8
`define SC_START 8'h08
`define SC_REP 8'h10
`define SC_W_ACK 8'h18
`define SC_W_NACK 8'h20
`define SC_D_ACK 8'h28
`define SC_D_NACK 8'h30
`define SC_ARB 8'h38
`define SC_R_ACK 8'h40
`define SC_R_NACK 8'h48
`define SC_B_ACK 8'h50
`define SC_B_NACK 8'h58
`define SC_NONE 8'hF8
`define TWC_QTR_NS 2500
`define TWC_CLK_MHZ 100
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// [src/tw_rx_pkg.sv]
package tw_rx_pkg;
  // Sequencer states of the bus engine
  typedef enum logic [2:0] {
    S_IDLE,
    S_START,
    S_HOLD,
    S_BYTE,
    S_STOP
  } core_state_e;
endpackage

// [src/two_wire_master_rx.sv]
// The implementer's own choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/10ps
`include "tw_rx_params.svh"
module two_wire_master_rx
  import tw_rx_pkg::*;
#(
  parameter int ADDR_W = 4,
  parameter int QTR_CYC = (`TWC_QTR_NS * `TWC_CLK_MHZ + 999) / 1000
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic awvalid,
  output logic awready,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [ADDR_W-1:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe
);
  // Timer reload: quarter bit time in clock cycles, rounded up, less one
  localparam logic [15:0] QTR_M1 = 16'(QTR_CYC - 1);

  // Bus slave state
  logic [ADDR_W-1:0] wa_r; // Latched write address
  logic [7:0] wd_r; // Latched write data, low lane
  logic wen_r; // Low byte lane enabled
  logic wr_fire; // Both halves of a write present

  // Control and status
  logic flag_r; // op_done_flag
  logic ack_en_r; // ack_enable
  logic sta_r; // start_request
  logic sto_r; // stop_request
  logic wcol_r; // write_collision_flag
  logic en_r; // iface_enable
  logic ie_r; // irq_enable, stored only
  logic [7:0] status_r; // bus_status_reg code
  logic [7:0] data_r; // bus_data_reg, also the shifter
  logic rx_mode_r; // master_receive_mode
  logic tx_mode_r; // master_transmit_mode

  // Bus engine
  core_state_e state_r;
  logic [15:0] cnt_r; // Quarter bit timer
  logic [1:0] ph_r; // Quarter within a bit
  logic [3:0] bit_r; // Bit within a byte, 8 is ack
  logic own_r; // We are master on the bus
  logic tx_r; // Byte goes out, not in
  logic addr_r; // Byte is an address packet
  logic rw_r; // Direction bit of that packet
  logic ackb_r; // Drive ACK after a received byte
  logic ackn_r; // Sampled ack bit, 1 = NACK
  logic samp_r; // Sampled data bit
  logic step; // Quarter expired
  logic bit_last; // Ack slot
  logic lost; // Arbitration lost this sample

  // Pin synchronisers and bus watch
  logic scl_m, scl_s, sda_m, sda_s, sda_q;
  logic busy_r; // Someone owns the bus
  logic [7:0] rd_mux;

  // Only word offsets the block decodes answer OKAY
  function automatic logic reg_hit(input logic [ADDR_W-1:0] a);
    reg_hit = (a == ADDR_W'(`TWC_CTRL_OFS)) || (a == ADDR_W'(`TWC_STAT_OFS)) ||
              (a == ADDR_W'(`TWC_DATA_OFS)) || (a == ADDR_W'(`TWC_MODE_OFS));
  endfunction

  // Status after the ninth bit of a byte
  function automatic logic [7:0] done_code(input logic tx, input logic ad,
                                           input logic rw, input logic nack,
                                           input logic ackb);
    if (!tx)
      done_code = ackb ? `SC_B_ACK : `SC_B_NACK;
    else if (ad && rw)
      done_code = nack ? `SC_R_NACK : `SC_R_ACK;
    else if (ad)
      done_code = nack ? `SC_W_NACK : `SC_W_ACK;
    else
      done_code = nack ? `SC_D_NACK : `SC_D_ACK;
  endfunction

  assign wr_fire = !awready && !wready && !bvalid;
  // Clock phase after release waits for the line to go high (stretching)
  assign step = (cnt_r == 16'h0000) && ((ph_r != 2'd2) || scl_s);
  assign bit_last = (bit_r == 4'd8);
  // Released our line but it reads low: someone else drives
  assign lost = (tx_r ? !bit_last : bit_last) && !sda_oe && !sda_s;

  // Read data selection
  always_comb begin
    case (araddr)
      ADDR_W'(`TWC_CTRL_OFS): rd_mux = {flag_r, ack_en_r, sta_r, sto_r, wcol_r, en_r,
                                        1'b0, ie_r};
      ADDR_W'(`TWC_STAT_OFS): rd_mux = {status_r[7:3], 3'b000};
      ADDR_W'(`TWC_DATA_OFS): rd_mux = data_r;
      ADDR_W'(`TWC_MODE_OFS): rd_mux = {5'h00, busy_r, tx_mode_r, rx_mode_r};
      default: rd_mux = 8'h00;
    endcase
  end

  // Write channel: address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
      wa_r <= '0;
      wd_r <= 8'h00;
      wen_r <= 1'b0;
    end else if (ce) begin
      if (awvalid && awready) begin
        wa_r <= awaddr;
        awready <= 1'b0;
      end
      if (wvalid && wready) begin
        wd_r <= wdata[7:0];
        wen_r <= wstrb[0];
        wready <= 1'b0;
      end
      if (wr_fire) begin
        bvalid <= 1'b1;
        bresp <= reg_hit(wa_r) ? `RESP_OKAY : `RESP_SLVERR;
      end
      // Both ready again only once the answer is taken
      if (bvalid && bready) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  // Read channel: one read at a time, data sampled at acceptance
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `RESP_OKAY;
    end else if (ce) begin
      if (arvalid && arready) begin
        arready <= 1'b0;
        rvalid <= 1'b1;
        rdata <= {24'h00_0000, rd_mux};
        rresp <= reg_hit(araddr) ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (rvalid && rready) begin
        rvalid <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

  // Two stages on each pin, a third on SDA for edges; the first stage is never looked at
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      sda_q <= 1'b1;
      scl_o <= 1'b0;
      sda_o <= 1'b0;
    end else if (ce) begin
      scl_m <= scl_i;
      scl_s <= scl_m;
      sda_m <= sda_i;
      sda_s <= sda_m;
      sda_q <= sda_s;
      scl_o <= 1'b0; // Open drain: only ever pulls low
      sda_o <= 1'b0;
    end
  end

  // Busy from START and STOP seen on the wire, our own included
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy_r <= 1'b0;
    end else if (ce) begin
      if (scl_s && sda_q && !sda_s) begin
        busy_r <= 1'b1;
      end else if (scl_s && !sda_q && sda_s) begin
        busy_r <= 1'b0;
      end
    end
  end

  // Registers and bus sequencer; hardware sets come last so they win
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_r <= 1'b0;
      ack_en_r <= 1'b0;
      sta_r <= 1'b0;
      sto_r <= 1'b0;
      wcol_r <= 1'b0;
      en_r <= 1'b0;
      ie_r <= 1'b0;
      status_r <= `TWC_STAT_RST;
      data_r <= `TWC_DATA_RST;
      rx_mode_r <= 1'b0;
      tx_mode_r <= 1'b0;
      state_r <= S_IDLE;
      cnt_r <= QTR_M1;
      ph_r <= 2'd0;
      bit_r <= 4'd0;
      own_r <= 1'b0;
      tx_r <= 1'b0;
      addr_r <= 1'b0;
      rw_r <= 1'b0;
      ackb_r <= 1'b0;
      ackn_r <= 1'b0;
      samp_r <= 1'b0;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
    end else if (ce) begin
      // Control write; a one in the flag bit clears it
      if (wr_fire && wen_r && wa_r == ADDR_W'(`TWC_CTRL_OFS)) begin
        ack_en_r <= wd_r[`TWC_ACK];
        sta_r <= wd_r[`TWC_STA];
        sto_r <= wd_r[`TWC_STO];
        en_r <= wd_r[`TWC_EN];
        ie_r <= wd_r[`TWC_IE];
        if (wd_r[`TWC_FLAG]) begin
          flag_r <= 1'b0;
        end
      end
      // Data write only while the flag is set, else a collision
      if (wr_fire && wen_r && wa_r == ADDR_W'(`TWC_DATA_OFS)) begin
        if (flag_r) begin
          data_r <= wd_r;
          wcol_r <= 1'b0;
        end else begin
          wcol_r <= 1'b1;
        end
      end
      if (cnt_r != 16'h0000) begin
        cnt_r <= cnt_r - 16'h0001;
      end
      if (!en_r) begin
        // Interface off: let go of both lines
        state_r <= S_IDLE;
        own_r <= 1'b0;
        scl_oe <= 1'b0;
        sda_oe <= 1'b0;
      end else begin
        case (state_r)
          S_IDLE: begin
            cnt_r <= QTR_M1;
            ph_r <= 2'd0;
            scl_oe <= 1'b0;
            sda_oe <= 1'b0;
            // Requested START waits until the bus is seen free
            if (sta_r && !flag_r && !busy_r) begin
              state_r <= S_START;
            end
          end
          S_START: begin
            if (step) begin
              cnt_r <= QTR_M1;
              ph_r <= ph_r + 2'd1;
              case (ph_r)
                2'd0: sda_oe <= 1'b0;
                2'd1: scl_oe <= 1'b0;
                2'd2: sda_oe <= 1'b1;
                default: begin
                  scl_oe <= 1'b1;
                  flag_r <= 1'b1;
                  status_r <= own_r ? `SC_REP : `SC_START;
                  own_r <= 1'b1;
                  rx_mode_r <= 1'b0;
                  tx_mode_r <= 1'b0;
                  state_r <= S_HOLD;
                end
              endcase
            end
          end
          S_HOLD: begin
            // Clock stays low from the last bit while flag is set, except after lost arbitration
            cnt_r <= QTR_M1;
            ph_r <= 2'd0;
            bit_r <= 4'd0;
            if (!flag_r) begin
              if (status_r == `SC_ARB) begin
                state_r <= S_IDLE;
                own_r <= 1'b0;
              end else if (sto_r) begin
                state_r <= S_STOP;
              end else if (sta_r) begin
                state_r <= S_START;
              end else if (status_r == `SC_R_ACK || status_r == `SC_B_ACK) begin
                tx_r <= 1'b0;
                addr_r <= 1'b0;
                ackb_r <= ack_en_r;
                state_r <= S_BYTE;
              end else begin
                tx_r <= 1'b1;
                addr_r <= (status_r == `SC_START) || (status_r == `SC_REP);
                rw_r <= data_r[0];
                state_r <= S_BYTE;
              end
            end
          end
          S_BYTE: begin
            if (step) begin
              cnt_r <= QTR_M1;
              ph_r <= ph_r + 2'd1;
              case (ph_r)
                2'd0: sda_oe <= bit_last ? (!tx_r && ackb_r) : (tx_r && !data_r[7]);
                2'd1: scl_oe <= 1'b0;
                2'd2: begin
                  if (bit_last) begin
                    ackn_r <= sda_s;
                  end else begin
                    samp_r <= sda_s;
                  end
                  if (lost) begin
                    // Give the bus away at once
                    scl_oe <= 1'b0;
                    sda_oe <= 1'b0;
                    flag_r <= 1'b1;
                    status_r <= `SC_ARB;
                    own_r <= 1'b0;
                    rx_mode_r <= 1'b0;
                    tx_mode_r <= 1'b0;
                    state_r <= S_HOLD;
                  end
                end
                default: begin
                  scl_oe <= 1'b1;
                  if (!bit_last) begin
                    data_r <= {data_r[6:0], samp_r};
                    bit_r <= bit_r + 4'd1;
                  end else begin
                    flag_r <= 1'b1;
                    status_r <= done_code(tx_r, addr_r, rw_r, ackn_r, ackb_r);
                    if (addr_r) begin
                      rx_mode_r <= rw_r;
                      tx_mode_r <= !rw_r;
                    end
                    state_r <= S_HOLD;
                  end
                end
              endcase
            end
          end
          S_STOP: begin
            if (step) begin
              cnt_r <= QTR_M1;
              ph_r <= ph_r + 2'd1;
              case (ph_r)
                2'd0: sda_oe <= 1'b1;
                2'd1: scl_oe <= 1'b0;
                2'd2: sda_oe <= 1'b1;
                default: begin
                  sda_oe <= 1'b0;
                  sto_r <= 1'b0;
                  own_r <= 1'b0;
                  rx_mode_r <= 1'b0;
                  tx_mode_r <= 1'b0;
                  status_r <= `SC_NONE;
                  // A START still requested follows once bus is free
                  state_r <= S_IDLE;
                end
              endcase
            end
          end
          default: state_r <= S_IDLE;
        endcase
      end
    end
  end
endmodule

// [testbench/tw_rx_monitor.sv]
`timescale 1ns/10ps
module tw_rx_monitor #(
  parameter int ADDR_W = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic rvalid,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic scl_oe,
  input wire logic sda_oe
);
  logic [ADDR_W-1:0] ra_r; // Register behind the read in flight
  // Tag each read answer with its address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ra_r <= '0;
    end else if (arvalid && arready) begin
      ra_r <= araddr;
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Bus answers come within the stated latency
  wr_answer_a: assert property (awvalid && awready && wvalid && wready |-> ##[1:2] bvalid)
    else $error("write answer missing");
  rd_answer_a: assert property (arvalid && arready |=> rvalid)
    else $error("read answer missing");
  // No new request taken while answering
  w_refuse_a: assert property (bvalid |-> !awready && !wready)
    else $error("write taken while answering");
  ar_refuse_a: assert property (rvalid |-> !arready)
    else $error("read taken while answering");
  unmapped_read_a: assert property (rvalid && ra_r >= 16 |-> rresp == 2'h2 && rdata == 32'h0)
    else $error("unmapped read not refused");
  // Status low bits read as zero, and line states that must stand behind a reported code
  status_low_a: assert property (rvalid && ra_r == 4 |-> rdata[2:0] == 3'h0)
    else $error("status low bits set");
  start_lines_a: assert property (
    rvalid && ra_r == 4 && rdata[7:0] inside {8'h08, 8'h10} |-> scl_oe && sda_oe)
    else $error("lines not held after start");
  clock_held_a: assert property (
    rvalid && ra_r == 4 && rdata[7:0] inside {8'h40, 8'h48, 8'h50, 8'h58} |-> scl_oe)
    else $error("clock not held while flag set");
  arb_release_a: assert property (
    rvalid && ra_r == 4 && rdata[7:0] == 8'h38 |-> !scl_oe && !sda_oe)
    else $error("lines kept after lost arbitration");
endmodule

bind two_wire_master_rx tw_rx_monitor #(.ADDR_W(ADDR_W)) mon (.aclk(aclk),
  .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .wvalid(wvalid),
  .wready(wready), .bvalid(bvalid), .arvalid(arvalid), .arready(arready),
  .araddr(araddr), .rvalid(rvalid), .rdata(rdata), .rresp(rresp), .scl_oe(scl_oe),
  .sda_oe(sda_oe));

// [testbench/slave_tx_model.sv]
`timescale 1ns/10ps
module slave_tx_model #(
  parameter logic [6:0] ADDR = 7'h2A
) (
  input wire logic scl,
  input wire logic sda,
  input wire logic [7:0] tx,
  input wire logic slow,
  output logic scl_pull,
  output logic sda_pull
);
  int bn; // Rising clocks seen in this byte
  int cnt; // Bytes sent since the address
  logic [7:0] sh; // Shift register
  logic hdr; // Next byte is an address
  logic rd; // Sending to the master
  initial begin
    bn = 0; cnt = 0; sh = 8'h0; hdr = 0; rd = 0; scl_pull = 0; sda_pull = 0;
  end
  // START or repeated START restarts framing
  always @(negedge sda) if (scl === 1'h1) begin
    bn = 0; cnt = 0; hdr = 1; rd = 0;
  end
  // STOP ends the frame
  always @(posedge sda) if (scl === 1'h1) begin
    hdr = 0; rd = 0; sda_pull = 0;
  end
  // Sample address bits; a NACK from the master stops sending
  always @(posedge scl) begin
    if (bn == 8 && rd && sda) rd = 0;
    else if (bn < 8 && !rd) sh = {sh[6:0], sda};
    bn = bn + 1;
  end
  // Change data only while the clock is low; stretch when slow
  always @(negedge scl) begin
    if (bn == 9) begin
      bn = 0; sda_pull = 0;
      if (rd) sh = tx + cnt[7:0];
      if (rd) cnt = cnt + 1;
    end
    if (bn == 8) begin
      if (hdr) begin
        hdr = 0;
        rd = sh[7:1] == ADDR && sh[0];
        sda_pull = sh[7:1] == ADDR; // Only own address is acknowledged
      end else sda_pull = 0; // Master owns the ack slot
    end else if (rd) begin
      sda_pull = !sh[7]; // MSB first
      sh = sh << 1;
    end
    if (slow) begin scl_pull = 1; #400 scl_pull = 0; end
  end
endmodule

// [testbench/two_wire_master_rx_test.sv]
`timescale 1ns/10ps
`include "tw_rx_params.svh"
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin miscompares++; \
  $display("FAIL %s expected %0h seen %0h", nm, e, g); end end
module two_wire_master_rx_test;
  localparam logic [6:0] SADR = 7'h2A; // Arbitrary slave address
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid;
  logic arready, rvalid, rready, scl_oe, sda_oe, s_scl, s_sda, tb_sda, slow;
  logic ce, scl_o, sda_o; // Clock enable, pin levels driven while enabled
  logic [3:0] strb; // Byte lanes of every write
  logic [4:0] awaddr, araddr;
  logic [31:0] wdata, rdata, seed, d;
  logic [1:0] bresp, rresp, lresp;
  logic [7:0] tx;
  logic [7:0] rv [4] = '{8'h00, 8'hF8, 8'hFF, 8'h00}; // Reset values
  logic [19:0] seq [13] = '{20'h0A408, 20'h28448, 20'h0A410, 20'h18440, 20'h08458,
    20'h0B408, 20'h28448, 20'h0B408, 20'h18440, 20'h08458, 20'h0A410, 20'h28448, 20'h094F8};
  int compares = 0, miscompares = 0, cyc = 0, n;
  // Pull-up wins once all release; an enabled pin shows its driven level
  wire scl = !((scl_oe && !scl_o) | s_scl);
  wire sda = !((sda_oe && !sda_o) | s_sda | tb_sda);
  two_wire_master_rx #(.ADDR_W(5), .QTR_CYC(2)) dut (.aclk(aclk), .aresetn(aresetn),
    .ce(ce), .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid),
    .wready(wready), .wdata(wdata), .wstrb(strb), .bvalid(bvalid), .bready(bready),
    .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp), .scl_i(scl),
    .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe));
  slave_tx_model #(.ADDR(SADR)) far (.scl(scl), .sda(sda), .tx(tx), .slow(slow),
    .scl_pull(s_scl), .sda_pull(s_sda));
  initial begin aclk = 0; forever #5 aclk = !aclk; end
  // Cut a hang short
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin miscompares++; stop_test(); end
  end
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Slave sends tx, tx+1, ... after each address
  function automatic logic [7:0] exp_byte(input int k);
    return tx + k[7:0];
  endfunction
  // Write: address and data together, each dropped once taken
  // A local flag ends the wait: ready NBAs are not yet seen in this time step
  task automatic wr(input logic [4:0] a, input logic [7:0] v);
    bit pend;
    pend = 1'b1;
    @(posedge aclk);
    awaddr <= a; wdata <= {24'h0, v}; awvalid <= 1; wvalid <= 1; bready <= 1;
    while (pend) begin
      @(posedge aclk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
      if (bvalid) begin bready <= 0; pend = 1'b0; `CHK("bresp", 2'h0, bresp) end
    end
  endtask
  task automatic rd(input logic [4:0] a, output logic [31:0] v);
    bit pend;
    pend = 1'b1;
    @(posedge aclk);
    araddr <= a; arvalid <= 1; rready <= 1;
    while (pend) begin
      @(posedge aclk);
      if (arready) arvalid <= 0;
      if (rvalid) begin rready <= 0; pend = 1'b0; v = rdata; lresp = rresp; end
    end
  endtask
  // Poll for the flag (or stop bit clear after STOP), then check the code
  task automatic wt(input logic [7:0] c, input logic [7:0] st);
    logic [31:0] v;
    v = {24'h0, c & 8'h10};
    for (int i = 0; i < 3000 && (c == 8'h94 ? v[4] : !v[7]); i++) rd(5'h0, v);
    `CHK("done", 1'h1, c == 8'h94 ? !v[4] : v[7])
    rd(5'h4, v);
    `CHK("status", st, v[7:0])
  endtask
  task automatic go(input logic [7:0] c, input logic [7:0] st);
    wr(5'h0, c);
    wt(c, st);
  endtask
  task automatic byte_chk(input int k);
    rd(5'h8, d);
    `CHK("rx_byte", exp_byte(k), d[7:0])
  endtask
  task automatic done(input string s);
    $display("test %s finished", s);
  endtask
  task automatic stop_test();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    aresetn = 0; awvalid = 0; wvalid = 0; bready = 0; arvalid = 0; rready = 0;
    awaddr = 0; araddr = 0; wdata = 0; tb_sda = 0; slow = 0; tx = 0; seed = 98;
    ce = 1; strb = 4'hF;
    repeat (5) @(posedge aclk);
    aresetn <= 1;
    // Reset values, unmapped read, data write refused while flag clear
    for (int i = 0; i < 4; i++) begin
      rd(5'(4 * i), d);
      `CHK("reset_value", rv[i], d[7:0])
    end
    rd(5'h10, d);
    `CHK("unmapped", 2'h2, lresp)
    wr(5'h8, 8'h55);
    rd(5'h8, d);
    `CHK("data_kept", 8'hFF, d[7:0])
    // Control write with its lane off must leave the register alone
    strb <= 4'h0;
    wr(5'h0, 8'h04);
    strb <= 4'hF;
    rd(5'h0, d);
    `CHK("collision", 8'h08, d[7:0])
    done("registers");
    // Another master holds the bus; START must wait for its STOP
    tb_sda <= 1;
    wr(5'h0, 8'hA4);
    repeat (50) @(posedge aclk);
    `CHK("wait_free", 1'h0, sda_oe)
    tb_sda <= 0;
    wt(8'hA4, 8'h08);
    done("start");
    // Random reads of 1..4 bytes, fast or stretched slave
    for (int r = 0; r < 3; r++) begin
      d = xs();
      tx = d[7:0]; slow = d[8]; n = 1 + d[10:9];
      if (r > 0) go(8'hA4, 8'h08);
      wr(5'h8, {SADR, 1'h1});
      repeat (40) @(posedge aclk);
      `CHK("held", 1'h1, scl_oe)
      wr(5'h0, 8'hC4);
      // Clock enable low must hold the engine mid-address
      ce <= 0;
      @(posedge aclk);
      d[1:0] = {scl_oe, sda_oe};
      repeat (30) @(posedge aclk);
      `CHK("frozen", d[1:0], {scl_oe, sda_oe})
      ce <= 1;
      wt(8'hC4, 8'h40);
      rd(5'hC, d);
      `CHK("mode", 1'h1, d[0])
      for (int k = 0; k < n; k++) begin
        go(k == n - 1 ? 8'h84 : 8'hC4, k == n - 1 ? 8'h58 : 8'h50);
        byte_chk(k);
      end
      go(8'h94, 8'hF8);
      done("receive");
    end
    // Answers to 48: repeated START, STOP, both; to 58: repeated START and both
    for (int i = 0; i < 13; i++) begin
      if (seq[i][17:16] != 2'h0) wr(5'h8, {seq[i][16] ? SADR : SADR ^ 7'h01, 1'h1});
      go(seq[i][15:8], seq[i][7:0]);
      if (seq[i][7:0] == 8'h58) byte_chk(0);
    end
    // A write packet switches to transmit mode
    go(8'hA4, 8'h08);
    wr(5'h8, {SADR, 1'h0});
    go(8'h84, 8'h18);
    rd(5'hC, d);
    `CHK("tx_mode", 2'h2, d[1:0])
    go(8'h94, 8'hF8);
    done("codes");
    // Lose arbitration in the address, then queue a START
    go(8'hA4, 8'h08);
    tb_sda <= 1;
    wr(5'h8, {SADR, 1'h1});
    go(8'h84, 8'h38);
    `CHK("released", 2'h0, {scl_oe, sda_oe})
    // Queued START must wait until the other master lets go
    wr(5'h0, 8'hA4);
    repeat (50) @(posedge aclk);
    `CHK("start_queued", 1'h0, sda_oe)
    tb_sda <= 0;
    wt(8'hA4, 8'h08);
    go(8'h94, 8'hF8);
    done("arbitration");
    stop_test();
  end
endmodule
